// ---- logic/adcc_consts.svh ----
// Offsets, fields, reset values and counts of the converter core.
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
`define ADCC_A_STATUS   8'h01
`define ADCC_A_DRATE    8'h04
`define ADCC_A_REFCTL   8'h05
`define ADCC_A_SYSCTL   8'h09
`define ADCC_A_OFS_LO   8'h0a
`define ADCC_A_OFS_HI   8'h0b
`define ADCC_A_GAIN_LO  8'h0c
`define ADCC_A_GAIN_HI  8'h0d
`define ADCC_A_GPIO_DAT 8'h10
`define ADCC_A_GPIO_SEL 8'h11
`define ADCC_ST_POR     7
`define ADCC_ST_NRDY    6
`define ADCC_ST_REFLOW  0
`define ADCC_DR_MODE    5
`define ADCC_DR_CLKEXT  6
`define ADCC_RC_MONEN   7
`define ADCC_SC_AVG_HI  1
`define ADCC_SC_AVG_LO  0
`define ADCC_SC_MON_HI  7
`define ADCC_SC_MON_LO  5
`define ADCC_DRATE_RST  8'h00
`define ADCC_REFCTL_RST 8'h00
`define ADCC_SYSCTL_RST 8'h00
`define ADCC_GPIO_RST   8'h00
`define ADCC_OFS_RST    16'h0000
`define ADCC_GAIN_RST   16'h4000
`define ADCC_MON_SHORT  3'h1
`define ADCC_INIT_CYC   4'h8
`define ADCC_UNITY_SH   14
`define ADCC_GAIN_NUM   32'h1fffc000
`define ADCC_GAIN_MAX   16'hffff
`define ADCC_POS_MAX    16'h7fff
`define ADCC_NEG_MIN    16'h8000
`endif

// ---- logic/adcc_core.sv ----
// Converter core control: flags, calibration, modes, registers.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_consts.svh"
// Contract
// R1 - Status bit 6 shows readiness after reset.
// R2 - Monitor latches reference below 300 mV.
// R3 - Monitor works only when enabled; flag bit 0.
// R4 - Low-reference bit updates at done falling edge.
// R5 - Function select makes pin general-purpose.
// R6 - Upper data bits set pin direction.
// R7 - Lower bits read input or drive output.
// R8 - Subtract offset, scale by gain, clip.
// R9 - Offset is signed; zero means no correction.
// R10 - Gain is unsigned; 4000h is unity.
// R11 - Calibration averages 1, 4, 8, 16 readings.
// R12 - Self offset shorts input, stores offset.
// R13 - System offset stores measured null input.
// R14 - System gain updates gain from full-scale.
// R15 - After calibration, convert and signal done.
// R16 - Calibration ignored in standby.
// R17 - Three modes; any reset acts immediately. The code ignores the reset command in power-down.
// R18 - Sleep aborts conversion, enters power-down.
// R19 - Start edge or command restarts conversion.
// R20 - Reset restores defaults, enters standby.
// R21 - Reset selects internal oscillator.
// R22 - Data rate bit selects conversion mode.
// R23 - Power-on sets bit 7 until written zero.
// R24 - Mode 0 continuous, mode 1 single-shot.
module adcc_core (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              por_rst,
    input  wire logic              start_pin,
    input  wire logic              ref_low_pin,
    input  wire logic              cmd_valid,
    input  wire adcc_pkg::adcc_cmd_t cmd_code,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    input  wire logic              filt_valid,
    input  wire logic [15:0]       filt_data,
    output logic      [15:0]       data_out,
    output logic                   conversion_done_strobe_n,
    output logic                   filt_restart,
    output logic                   conv_active,
    output logic                   power_down,
    output logic                   clk_ext_sel,
    output logic      [2:0]        monitor_select,
    input  wire logic [3:0]        gpio_in,
    output logic      [3:0]        gpio_out,
    output logic      [3:0]        gpio_oe,
    output logic      [3:0]        pin_function_select
);
    import adcc_pkg::*;

    adcc_state_t  state_q, state_d;
    adcc_cal_t    kind_q, kind_d;
    logic [2:0]   st_sy_q, rf_sy_q;
    logic         st_lvl_q, st_lvl_d, st_prv_q, rf_lvl_q, rf_lvl_d;
    logic [7:0]   drate_q, drate_d, refctl_q, refctl_d, sysctl_q, sysctl_d;
    logic [7:0]   gdat_q, gdat_d, gsel_q, gsel_d, rdata_q, rdata_d;
    logic [15:0]  ofs_q, ofs_d, gain_q, gain_d;
    logic         por_q, por_d, reflow_q, reflow_d, fault_q, fault_d;
    logic         stop_q, stop_d, done_n_q, done_n_d, rstart_q, rstart_d;
    logic [3:0]   init_q, init_d;
    logic [4:0]   cnt_q, cnt_d;
    logic signed [19:0] sum_q, sum_d;
    logic [15:0]  avg;
    logic [3:0]   gpio_rd;
    logic         soft_rst, busy, start_ev, stop_ev, res, last;

    // Averaging count as a shift.
    function automatic logic [2:0] avg_shift(input logic [1:0] c);
        unique case (c)
            2'h0:    avg_shift = 3'h0;
            2'h1:    avg_shift = 3'h2;
            2'h2:    avg_shift = 3'h3;
            default: avg_shift = 3'h4;
        endcase
    endfunction

    // Gain mapping full scale to the top code.
    function automatic logic [15:0] gain_fit(input logic [15:0] a, o);
        logic signed [16:0] d;
        logic [31:0]        q;
        d = $signed({a[15], a}) - $signed({o[15], o});
        q = 32'h0;
        if (d <= 17'sh0)
            gain_fit = `ADCC_GAIN_MAX;
        else
        begin
            q = `ADCC_GAIN_NUM / {15'h0, d};
            gain_fit = (q > {16'h0, `ADCC_GAIN_MAX}) ? `ADCC_GAIN_MAX : q[15:0];
        end
    endfunction

    function automatic logic is_cmd(input logic v, input adcc_cmd_t c, w);
        is_cmd = v && (c == w);
    endfunction

    // Resets act at once, but a reset command is ignored while asleep.
    assign soft_rst = rst || por_rst
        || (is_cmd(cmd_valid, cmd_code, CMD_RESET) && state_q != ST_PDN); // R17
    assign busy     = (init_q != 4'h0);
    assign start_ev = (st_lvl_q && !st_prv_q) || is_cmd(cmd_valid, cmd_code, CMD_START); // R19
    assign stop_ev  = (!st_lvl_q && st_prv_q) || is_cmd(cmd_valid, cmd_code, CMD_STOP);
    assign res      = filt_valid && (state_q == ST_CONV || state_q == ST_CAL);
    assign last     = (cnt_q == 5'(5'h1 << avg_shift(sysctl_q[`ADCC_SC_AVG_HI:`ADCC_SC_AVG_LO]))); // R11
    assign avg      = 16'(sum_q >>> avg_shift(sysctl_q[`ADCC_SC_AVG_HI:`ADCC_SC_AVG_LO])); // R11

    // Levels count once two stages agree.
    always_comb
    begin
        st_lvl_d = (st_sy_q[1] == st_sy_q[2]) ? st_sy_q[2] : st_lvl_q;
        rf_lvl_d = (rf_sy_q[1] == rf_sy_q[2]) ? rf_sy_q[2] : rf_lvl_q;
    end

    // Pin synchronisers.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_sy_q  <= 3'h0;
            rf_sy_q  <= 3'h0;
            st_lvl_q <= 1'b0;
            st_prv_q <= 1'b0;
            rf_lvl_q <= 1'b0;
        end
        else
        begin
            st_sy_q  <= {st_sy_q[1:0], start_pin};
            rf_sy_q  <= {rf_sy_q[1:0], ref_low_pin};
            st_lvl_q <= st_lvl_d;
            st_prv_q <= st_lvl_q;
            rf_lvl_q <= rf_lvl_d;
        end
    end

    // Next register and mode values.
    always_comb
    begin
        state_d  = state_q;
        kind_d   = kind_q;
        drate_d  = drate_q;
        refctl_d = refctl_q;
        sysctl_d = sysctl_q;
        gdat_d   = gdat_q;
        gsel_d   = gsel_q;
        ofs_d    = ofs_q;
        gain_d   = gain_q;
        por_d    = por_q;
        reflow_d = reflow_q;
        fault_d  = fault_q;
        stop_d   = stop_q;
        done_n_d = done_n_q | reg_rd;
        rstart_d = 1'b0;
        cnt_d    = cnt_q;
        sum_d    = sum_q;
        init_d   = busy ? init_q - 4'h1 : init_q; // R1
        rdata_d  = rdata_q;
        // Writes are refused while busy or asleep.
        if (reg_wr && !busy && state_q != ST_PDN)
        begin
            unique case (reg_addr)
                `ADCC_A_STATUS:   por_d = por_q & reg_wdata[`ADCC_ST_POR]; // R23
                `ADCC_A_DRATE:    drate_d = reg_wdata; // R22
                `ADCC_A_REFCTL:   refctl_d = reg_wdata; // R3
                `ADCC_A_SYSCTL:   sysctl_d = reg_wdata; // R11
                `ADCC_A_OFS_LO:   ofs_d[7:0] = reg_wdata; // R9
                `ADCC_A_OFS_HI:   ofs_d[15:8] = reg_wdata; // R9
                `ADCC_A_GAIN_LO:  gain_d[7:0] = reg_wdata; // R10
                `ADCC_A_GAIN_HI:  gain_d[15:8] = reg_wdata; // R10
                `ADCC_A_GPIO_DAT: gdat_d = reg_wdata; // R6 R7
                `ADCC_A_GPIO_SEL: gsel_d = reg_wdata; // R5
                default:          ;
            endcase
        end
        // Read data; unmapped addresses read zero.
        if (reg_rd)
        begin
            unique case (reg_addr)
                `ADCC_A_STATUS:   rdata_d = {por_q, busy, 5'h00, reflow_q}; // R1 R3
                `ADCC_A_DRATE:    rdata_d = drate_q;
                `ADCC_A_REFCTL:   rdata_d = refctl_q;
                `ADCC_A_SYSCTL:   rdata_d = sysctl_q;
                `ADCC_A_OFS_LO:   rdata_d = ofs_q[7:0];
                `ADCC_A_OFS_HI:   rdata_d = ofs_q[15:8];
                `ADCC_A_GAIN_LO:  rdata_d = gain_q[7:0];
                `ADCC_A_GAIN_HI:  rdata_d = gain_q[15:8];
                `ADCC_A_GPIO_DAT: rdata_d = {gdat_q[7:4], gpio_rd}; // R7
                `ADCC_A_GPIO_SEL: rdata_d = gsel_q;
                default:          rdata_d = 8'h00;
            endcase
        end
        // A fault is held until the conversion ends.
        if (refctl_q[`ADCC_RC_MONEN] && conv_active && rf_lvl_q)
            fault_d = 1'b1; // R2 R3
        unique case (state_q)
            ST_PDN:
            begin
                if (is_cmd(cmd_valid, cmd_code, CMD_WAKEUP))
                    state_d = ST_STBY;
            end
            ST_STBY:
            begin
                if (start_ev)
                begin
                    state_d  = ST_CONV; // R19
                    rstart_d = 1'b1;
                    done_n_d = 1'b1;
                    stop_d   = 1'b0;
                    fault_d  = 1'b0;
                end
                else if (is_cmd(cmd_valid, cmd_code, CMD_SLEEP))
                    state_d = ST_PDN;
            end
            ST_CONV, ST_CAL:
            begin
                if (is_cmd(cmd_valid, cmd_code, CMD_SLEEP))
                begin
                    state_d  = ST_PDN; // R18
                    done_n_d = 1'b1;
                    fault_d  = 1'b0;
                end
                else if (start_ev)
                begin
                    state_d  = ST_CONV; // R19
                    rstart_d = 1'b1;
                    done_n_d = 1'b1;
                    stop_d   = 1'b0;
                    fault_d  = 1'b0;
                end
                else if (state_q == ST_CONV && cmd_valid
                         && (cmd_code == CMD_SELF_OFFSET_CAL_CMD || cmd_code == CMD_SYSTEM_OFFSET_CAL_CMD || cmd_code == CMD_SYSTEM_GAIN_CAL_CMD))
                begin
                    state_d  = ST_CAL; // R16
                    kind_d   = (cmd_code == CMD_SELF_OFFSET_CAL_CMD) ? CAL_SELF_OFS
                             : (cmd_code == CMD_SYSTEM_OFFSET_CAL_CMD) ? CAL_SYS_OFS : CAL_SYS_GAIN;
                    rstart_d = 1'b1;
                    done_n_d = 1'b1;
                    cnt_d    = 5'h0;
                    sum_d    = 20'sh0;
                end
                else if (state_q == ST_CONV)
                begin
                    if (stop_ev)
                        stop_d = 1'b1;
                    if (res)
                    begin
                        done_n_d = 1'b0; // R4
                        reflow_d = fault_q | fault_d; // R4
                        fault_d  = 1'b0;
                        if (drate_q[`ADCC_DR_MODE] || stop_q || stop_ev)
                            state_d = ST_STBY; // R24
                    end
                end
                else if (res)
                begin
                    sum_d = sum_q + 20'($signed(filt_data)); // R11
                    cnt_d = cnt_q + 5'h1;
                end
                else if (last)
                begin
                    // Store the averaged reading as offset, or the gain fitted to it.
                    if (kind_q == CAL_SYS_GAIN)
                        gain_d = gain_fit(avg, ofs_q); // R14
                    else
                        ofs_d = avg; // R12 R13
                    state_d  = ST_CONV; // R15
                    rstart_d = 1'b1;
                    fault_d  = 1'b0;
                end
            end
            default: state_d = ST_STBY;
        endcase
    end

    // Control state; rst, por_rst and a reset command outside power-down restore defaults.
    always_ff @(posedge core_clk)
    begin
        if (soft_rst)
        begin
            state_q  <= ST_STBY; // R17 R20
            kind_q   <= CAL_SELF_OFS;
            drate_q  <= `ADCC_DRATE_RST; // R21
            refctl_q <= `ADCC_REFCTL_RST;
            sysctl_q <= `ADCC_SYSCTL_RST;
            gdat_q   <= `ADCC_GPIO_RST;
            gsel_q   <= `ADCC_GPIO_RST;
            ofs_q    <= `ADCC_OFS_RST;
            gain_q   <= `ADCC_GAIN_RST;
            por_q    <= por_q | por_rst; // R23
            reflow_q <= 1'b0;
            fault_q  <= 1'b0;
            stop_q   <= 1'b0;
            done_n_q <= 1'b1;
            rstart_q <= 1'b0;
            cnt_q    <= 5'h0;
            sum_q    <= 20'sh0;
            init_q   <= `ADCC_INIT_CYC; // R1
            rdata_q  <= 8'h00;
        end
        else
        begin
            state_q  <= state_d;
            kind_q   <= kind_d;
            drate_q  <= drate_d;
            refctl_q <= refctl_d;
            sysctl_q <= sysctl_d;
            gdat_q   <= gdat_d;
            gsel_q   <= gsel_d;
            ofs_q    <= ofs_d;
            gain_q   <= gain_d;
            por_q    <= por_d;
            reflow_q <= reflow_d;
            fault_q  <= fault_d;
            stop_q   <= stop_d;
            done_n_q <= done_n_d;
            rstart_q <= rstart_d;
            cnt_q    <= cnt_d;
            sum_q    <= sum_d;
            init_q   <= init_d;
            rdata_q  <= rdata_d;
        end
    end

    // Self offset forces the shorted input.
    assign monitor_select = (state_q == ST_CAL && kind_q == CAL_SELF_OFS)
        ? `ADCC_MON_SHORT : sysctl_q[`ADCC_SC_MON_HI:`ADCC_SC_MON_LO]; // R12
    assign conv_active  = (state_q == ST_CONV) || (state_q == ST_CAL);
    assign power_down   = (state_q == ST_PDN);
    assign clk_ext_sel  = drate_q[`ADCC_DR_CLKEXT]; // R21
    assign filt_restart = rstart_q;
    assign reg_rdata    = rdata_q;
    assign conversion_done_strobe_n = done_n_q; // R15
    assign pin_function_select = gsel_q[3:0];

    adcc_corr u_corr (
        .core_clk               (core_clk),
        .rst                    (rst),
        .res_valid              (res && state_q == ST_CONV),
        .res_raw                (filt_data),
        .offset_correction_word (ofs_q),
        .gain_correction_word   (gain_q),
        .res_out                (data_out)
    );

    adcc_gpio u_gpio (
        .core_clk            (core_clk),
        .rst                 (rst),
        .pin_in              (gpio_in),
        .pin_function_select (gsel_q[3:0]),
        .pin_dir_out         (gdat_q[7:4]),
        .pin_value_bits      (gdat_q[3:0]),
        .pin_out             (gpio_out),
        .pin_oe              (gpio_oe),
        .pin_read            (gpio_rd)
    );
endmodule // adcc_core
`default_nettype wire

// ---- logic/adcc_corr.sv ----
// Offset and gain correction of filter results with 16-bit clipping.
`timescale 1ns/100ps
`default_nettype none
`include "adcc_consts.svh"
module adcc_corr (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        res_valid,
    input  wire logic [15:0] res_raw,
    input  wire logic [15:0] offset_correction_word,
    input  wire logic [15:0] gain_correction_word,
    output logic      [15:0] res_out
);
    logic [15:0] res_q;
    logic [15:0] res_d;
    logic signed [16:0] diff;
    logic signed [33:0] prod;
    logic signed [33:0] scl;

    // Saturate to the 16-bit code range.
    function automatic logic [15:0] clip16(input logic signed [33:0] v);
        if (v > $signed({18'h0, `ADCC_POS_MAX}))
            clip16 = `ADCC_POS_MAX;
        else if (v < -$signed({18'h0, `ADCC_NEG_MIN}))
            clip16 = `ADCC_NEG_MIN;
        else
            clip16 = v[15:0];
    endfunction

    // Offset, gain and clip; the gain word is unsigned.
    always_comb
    begin
        diff  = $signed({res_raw[15], res_raw}) - $signed({offset_correction_word[15], offset_correction_word}); // R8
        prod  = 34'(diff) * $signed({18'h0, gain_correction_word}); // R8
        scl   = prod >>> `ADCC_UNITY_SH; // R10
        res_d = res_valid ? clip16(scl) : res_q; // R8
    end

    // Result register.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            res_q <= 16'h0000;
        else
            res_q <= res_d;
    end

    assign res_out = res_q;
endmodule // adcc_corr
`default_nettype wire

// ---- logic/adcc_gpio.sv ----
// Four general-purpose pins with per-pin function select and direction.
`timescale 1ns/100ps
`default_nettype none
module adcc_gpio (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [3:0] pin_in,
    input  wire logic [3:0] pin_function_select,
    input  wire logic [3:0] pin_dir_out,
    input  wire logic [3:0] pin_value_bits,
    output logic      [3:0] pin_out,
    output logic      [3:0] pin_oe,
    output logic      [3:0] pin_read
);
    logic [3:0] sy0_q;
    logic [3:0] sy1_q;
    logic [3:0] sy2_q;
    logic [3:0] lvl_q;
    logic [3:0] lvl_d;

    // A level counts once two stages agree.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            lvl_d[i] = (sy1_q[i] == sy2_q[i]) ? sy2_q[i] : lvl_q[i];
    end

    // Pin synchroniser.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sy0_q <= 4'h0;
            sy1_q <= 4'h0;
            sy2_q <= 4'h0;
            lvl_q <= 4'h0;
        end
        else
        begin
            sy0_q <= pin_in;
            sy1_q <= sy0_q;
            sy2_q <= sy1_q;
            lvl_q <= lvl_d;
        end
    end

    // Drive only digital output pins; unselected pins stay analog.
    assign pin_oe   = pin_function_select & pin_dir_out; // R5 R6
    assign pin_out  = pin_value_bits & pin_oe; // R7
    assign pin_read = (pin_dir_out & pin_value_bits) | (~pin_dir_out & lvl_q & pin_function_select); // R7
endmodule // adcc_gpio
`default_nettype wire

// ---- logic/adcc_pkg.sv ----
// Types shared by the converter core modules.
package adcc_pkg;
    typedef enum logic [3:0] {
        ST_STBY = 4'b0001,
        ST_CONV = 4'b0010,
        ST_CAL  = 4'b0100,
        ST_PDN  = 4'b1000
    } adcc_state_t;
    typedef enum logic [3:0] {
        CMD_NOP    = 4'h0,
        CMD_WAKEUP = 4'h1,
        CMD_SLEEP  = 4'h2,
        CMD_RESET  = 4'h3,
        CMD_START  = 4'h4,
        CMD_STOP   = 4'h5,
        CMD_SELF_OFFSET_CAL_CMD = 4'h6,
        CMD_SYSTEM_OFFSET_CAL_CMD = 4'h7,
        CMD_SYSTEM_GAIN_CAL_CMD = 4'h8
    } adcc_cmd_t;
    typedef enum logic [1:0] {
        CAL_SELF_OFS = 2'h0,
        CAL_SYS_OFS  = 2'h1,
        CAL_SYS_GAIN = 2'h2
    } adcc_cal_t;
endpackage

// ---- tb/adcc_asserts.sv ----
// Checks on the converter core ports.
`timescale 1ns/100ps
`default_nettype none
module adcc_asserts
    import adcc_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                rst,
    input wire logic                por_rst,
    input wire logic                cmd_valid,
    input wire adcc_pkg::adcc_cmd_t cmd_code,
    input wire logic                filt_valid,
    input wire logic                conversion_done_strobe_n,
    input wire logic                filt_restart,
    input wire logic                conv_active,
    input wire logic                power_down,
    input wire logic                clk_ext_sel,
    input wire logic [2:0]          monitor_select,
    input wire logic [3:0]          gpio_oe,
    input wire logic [3:0]          pin_function_select
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst || por_rst);
    // Reset lands in standby on the internal clock.
    a_reset_to_standby: assert property (disable iff (por_rst) rst |=> !conv_active && !power_down && !clk_ext_sel)
        else $error("reset missed standby");
    a_sleep_aborts_now: assert property (cmd_valid && cmd_code == CMD_SLEEP |=> power_down && !conv_active)
        else $error("sleep ignored");
    a_start_restarts: assert property (cmd_valid && cmd_code == CMD_START && !power_down |=> filt_restart && conv_active)
        else $error("start ignored");
    a_cal_idle_ignored: assert property (cmd_valid && cmd_code inside {CMD_SELF_OFFSET_CAL_CMD, CMD_SYSTEM_OFFSET_CAL_CMD, CMD_SYSTEM_GAIN_CAL_CMD} && !conv_active
        |=> !filt_restart && !conv_active) else $error("cal in standby");
    a_self_cal_short: assert property (cmd_valid && cmd_code == CMD_SELF_OFFSET_CAL_CMD && conv_active |=> (monitor_select == 3'h1) [*3])
        else $error("input not shorted");
    a_done_after_result: assert property ($fell(conversion_done_strobe_n) |-> $past(filt_valid))
        else $error("done without result");
    a_restart_done_high: assert property (filt_restart |-> conversion_done_strobe_n)
        else $error("done low at restart");
    a_sleep_quiet: assert property (power_down |-> !conv_active && !filt_restart && conversion_done_strobe_n)
        else $error("activity in power-down");
    a_pin_select_gate: assert property ((gpio_oe & ~pin_function_select) == 4'h0)
        else $error("unselected pin driven");
endmodule // adcc_asserts
bind adcc_core adcc_asserts i_adcc_asserts (.core_clk, .rst, .por_rst, .cmd_valid, .cmd_code, .filt_valid,
    .conversion_done_strobe_n, .filt_restart, .conv_active, .power_down, .clk_ext_sel, .monitor_select, .gpio_oe,
    .pin_function_select);
`default_nettype wire

// ---- tb/adcc_core_tb_top.sv ----
// Bench for the converter core.
`timescale 1ns/100ps
`default_nettype none
module adcc_core_tb_top;
    import adcc_pkg::*;
    logic       core_clk, rst, por_rst, start_pin, ref_low_pin, cmd_valid, reg_wr, reg_rd, filt_valid, done_n;
    logic       filt_restart, conv_active, power_down, clk_ext_sel;
    adcc_cmd_t  cmd_code;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, w;
    logic [15:0] filt_data, data_out, level, ofs, gain;
    logic [3:0] gpio_in, gpio_out, gpio_oe, sel, fsel, gap;
    logic [2:0] mon;
    int         errors, checks_done, cyc, n, f, seed;
    logic [7:0] ra[9] = '{8'h04, 8'h05, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11};
    adcc_core i_adcc_core (.core_clk, .rst, .por_rst, .start_pin, .ref_low_pin, .cmd_valid, .cmd_code, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .filt_valid, .filt_data, .data_out,
        .conversion_done_strobe_n(done_n), .filt_restart, .conv_active, .power_down, .clk_ext_sel,
        .monitor_select(mon), .gpio_in, .gpio_out, .gpio_oe, .pin_function_select(sel));
    adcc_filt_model i_adcc_filt_model (.core_clk, .filt_restart, .conv_active, .gap, .level, .filt_valid, .filt_data);
    task automatic print_verdict();
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic cmd(input adcc_cmd_t c);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic wait_done();
        int t = 0;
        do
            @(negedge core_clk);
        while (done_n !== 1'b0 && ++t < 300);
        chk(16'(t < 300), 16'h1);
    endtask
    // Expected corrected result.
    function automatic logic [15:0] corr(input logic [15:0] r, o, g);
        longint p;
        p = ((longint'($signed(r)) - longint'($signed(o))) * longint'(g)) >>> 14;
        return (p > 32767) ? 16'h7fff : (p < -32768) ? 16'h8000 : p[15:0];
    endfunction
    // Clock and hang guard.
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (++cyc == 30000)
        begin
            errors++;
            print_verdict();
        end
    // Status, defaults, pins, correction, calibration, modes.
    initial
    begin
        {rst, por_rst, start_pin, ref_low_pin, cmd_valid, reg_wr, reg_rd} = 7'h60;
        {reg_addr, reg_wdata, gpio_in, level, gap} = '0;
        cmd_code = CMD_NOP;
        seed = 32'h0bde99ac;
        repeat (16) @(posedge core_clk);
        rst     <= 1'b0;
        por_rst <= 1'b0;
        rd(8'h01);
        chk(v, 8'hc0);
        repeat (10) @(posedge core_clk);
        rd(8'h01);
        chk(v, 8'h80);
        wr(8'h01, 8'h00);
        rd(8'h01);
        chk(v, 8'h00);
        foreach (ra[i])
        begin
            rd(ra[i]);
            chk(v, (ra[i] == 8'h0d) ? 8'h40 : 8'h00);
        end
        repeat (4)
        begin
            w = 8'($random(seed));
            fsel = 4'($random(seed));
            gpio_in <= 4'($random(seed));
            wr(8'h11, {4'h0, fsel});
            wr(8'h10, w);
            repeat (5) @(posedge core_clk);
            rd(8'h10);
            chk(gpio_oe, fsel & w[7:4]);
            chk(gpio_out & gpio_oe, w[3:0] & gpio_oe);
            chk(v[7:4], w[7:4]);
            chk(v[3:0] & (fsel | ~w[7:4]), (gpio_in & fsel & ~w[7:4]) | (w[3:0] & w[7:4] & fsel));
        end
        wr(8'h04, 8'h20);
        for (int i = 0; i < 8; i++)
        begin
            ofs = i ? 16'($random(seed)) : 16'h0000;
            gain = i ? 16'($random(seed)) : 16'h4000;
            level = 16'($random(seed));
            gap <= 4'(i + 2);
            ref_low_pin <= i[1];
            wr(8'h05, {i[0], 7'h0});
            for (int b = 0; b < 4; b++)
                wr(8'(8'h0a + b), 8'({gain, ofs} >> (8 * b)));
            if (i[2])
                start_pin <= 1'b1;
            else
                cmd(CMD_START);
            wait_done();
            chk(data_out, corr(level, ofs, gain));
            rd(8'h01);
            chk(v[0], i[0] & i[1]);
            chk(conv_active, 1'b0);
            start_pin <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
        wr(8'h04, 8'h00);
        wr(8'h0a, 8'h00);
        wr(8'h0b, 8'h00);
        gap <= 4'h3;
        cmd(CMD_SELF_OFFSET_CAL_CMD);
        cmd(CMD_START);
        for (int k = 0; k < 6; k++)
        begin
            level = (k < 4) ? 16'($random(seed)) : (k == 4) ? 16'h0010 : 16'h4010;
            f = k & 3;
            wr(8'h09, 8'(k));
            cmd((k < 4) ? CMD_SELF_OFFSET_CAL_CMD : (k == 4) ? CMD_SYSTEM_OFFSET_CAL_CMD : CMD_SYSTEM_GAIN_CAL_CMD);
            n = 0;
            for (int j = 0; j < 400 && !(filt_restart && n > 0); j++)
            begin
                @(negedge core_clk);
                n += int'(filt_valid && !filt_restart);
            end
            chk(16'(n), f ? 16'(1 << (f + 1)) : 16'h1);
            rd((k == 5) ? 8'h0d : 8'h0b);
            w = v;
            rd((k == 5) ? 8'h0c : 8'h0a);
            chk({w, v}, (k == 5) ? 16'h7fff : level);
        end
        cmd(CMD_SLEEP);
        wr(8'h04, 8'h40);
        rd(8'h04);
        chk(v, 8'h00);
        chk(power_down, 1'b1);
        cmd(CMD_WAKEUP);
        repeat (2) @(posedge core_clk);
        wr(8'h04, 8'h40);
        @(negedge core_clk);
        chk(clk_ext_sel, 1'b1);
        cmd(CMD_RESET);
        @(negedge core_clk);
        chk(clk_ext_sel, 1'b0);
        rd(8'h04);
        chk(v, 8'h00);
        print_verdict();
    end
endmodule // adcc_core_tb_top
`default_nettype wire

// ---- tb/adcc_filt_model.sv ----
// Filter and input source model.
`timescale 1ns/100ps
`default_nettype none
module adcc_filt_model (
    input  wire logic        core_clk,
    input  wire logic        filt_restart,
    input  wire logic        conv_active,
    input  wire logic [3:0]  gap,
    input  wire logic [15:0] level,
    output logic             filt_valid,
    output logic      [15:0] filt_data
);
    logic [3:0] cnt_q;
    // Results carry level; the bus is inverted between them.
    always_ff @(posedge core_clk)
    begin
        cnt_q <= (filt_restart || !conv_active || cnt_q == gap) ? 4'h0 : cnt_q + 4'h1;
        filt_valid <= conv_active && !filt_restart && cnt_q == gap;
        filt_data <= (conv_active && !filt_restart && cnt_q == gap) ? level : ~level;
    end
endmodule // adcc_filt_model
`default_nettype wire
